// >>> capture_compare_pulse_accumulator.v
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "ccpa_regs.vh"
module capture_compare_pulse_accumulator #(
    parameter NCH = 4
) (
    input wire i_sys_clk,
    input wire i_rst_n,
    input wire i_clk_en,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    input wire [3:0] i_pin,
    output reg [3:0] o_pin,
    output reg [3:0] o_pin_oe,
    output reg o_irq
);

    // Select bit 0 takes rising edges and bit 1 falling ones; both together take any edge
    function edge_hit;
        input [1:0] sel;
        input prev;
        input cur;
        begin
            edge_hit = (sel[0] & ~prev & cur) | (sel[1] & prev & ~cur);
        end
    endfunction

    function [6:0] div_mask;
        input [2:0] sel;
        begin
            div_mask = (7'h01 << sel) - 7'h01;
        end
    endfunction

    // Channel value registers sit on consecutive words from the first one
    function [11:0] ch_addr;
        input [1:0] idx;
        begin
            ch_addr = `A_CH0 + {8'h00, idx, 2'b00};
        end
    endfunction

    reg [`CTRL_W-1:0] ctrl_r;
    reg [3:0] sel_r;
    reg [3:0] chie_r;
    reg [7:0] edge_r;
    reg [7:0] outctl_r;
    reg [3:0] oc3m_r;
    reg [3:0] oc3d_r;
    reg [15:0] cnt_r;
    reg [6:0] presc_r;
    reg [2:0] pr_act_r;
    reg [3:0] chf_r;
    reg tof_r;
    reg ain_r;
    reg aov_r;
    reg [3:0] port_r;
    reg [3:0] dir_r;
    reg [15:0] acc_r;
    reg [15:0] ch_r [0:3];
    reg [3:0] oc_r;
    reg [3:0] pin_m_r;
    reg [3:0] pin_s_r;
    reg [3:0] pin_p_r;

    wire en = ctrl_r[`CTRL_EN];
    wire ffc = ctrl_r[`CTRL_FFC];
    wire counter_reset_on_ch3 = ctrl_r[`CTRL_COUNTER_RESET_ON_CH3];
    wire amod = ctrl_r[`CTRL_AMOD];
    wire aedg = ctrl_r[`CTRL_AEDG];
    wire [2:0] pr_sel = ctrl_r[`CTRL_PR_HI:`CTRL_PR_LO];

    // Slave answers one cycle after the access phase starts; effects land on completion
    wire acc_ph = i_psel & i_penable;
    wire done = acc_ph & o_pready;
    wire wr = done & i_pwrite;
    wire rd = done & ~i_pwrite;
    wire acc_first = acc_ph & ~o_pready;

    wire tick = en && ((presc_r & div_mask(pr_act_r)) == div_mask(pr_act_r));
    // Shares the prescaler, so gated counting stops whenever the timer does
    wire div64 = en && (presc_r[5:0] == `DIV64_PHASE);
    wire ch3_hit = tick && sel_r[3] && (cnt_r == ch_r[3]);
    wire cnt_reset = ch3_hit && counter_reset_on_ch3;
    wire cnt_wrap = tick && (cnt_r == `CNT_MAX);
    // A channel 3 restart at the top count is not an overflow
    wire tof_set = cnt_wrap && !(counter_reset_on_ch3 && ch_r[3] == `CNT_MAX);
    wire [15:0] cnt_nxt = cnt_reset ? `CNT_ZERO : cnt_r + 16'h0001;
    wire [6:0] presc_nxt = en ? presc_r + 7'h01 : 7'h00;
    wire [15:0] acc_nxt = acc_r + 16'h0001;

    reg [3:0] cmp_hit;
    reg [3:0] cap_hit;
    reg [3:0] force_v;
    reg [3:0] oc_nxt;
    reg [3:0] pin_own;
    integer k;
    integer k_oc;
    integer k_clr;
    integer k_ch;

    // Event detection per channel, kept apart from the pin action
    always @* begin
        for (k = 0; k < NCH; k = k + 1) begin
            cmp_hit[k] = tick && sel_r[k] && (cnt_r == ch_r[k]);
            // Capture needs the timer running and an input-direction pin
            cap_hit[k] = en && !sel_r[k] && !dir_r[k] &&
                edge_hit(edge_r[2*k +: 2], pin_p_r[k], pin_s_r[k]);
            // Compare logic takes the pin only while it has something to drive
            pin_own[k] = sel_r[k] && ((outctl_r[2*k +: 2] != 2'b00) || oc3m_r[k]);
        end
    end

    always @* begin
        force_v = (wr && i_paddr == `A_FORCE) ? i_pwdata[3:0] : 4'h0;
        oc_nxt = oc_r;
        for (k_oc = 0; k_oc < NCH; k_oc = k_oc + 1) begin
            if ((cmp_hit[k_oc] || force_v[k_oc]) && sel_r[k_oc]) begin
                case (outctl_r[2*k_oc +: 2])
                    2'b01: oc_nxt[k_oc] = ~oc_r[k_oc];
                    2'b10: oc_nxt[k_oc] = 1'b0;
                    2'b11: oc_nxt[k_oc] = 1'b1;
                    default: oc_nxt[k_oc] = oc_r[k_oc];
                endcase
            end
        end
        // Channel 3 wins over same-cycle actions of the other channels
        if (ch3_hit || (force_v[3] && sel_r[3])) begin
            for (k_oc = 0; k_oc < NCH; k_oc = k_oc + 1) begin
                if (oc3m_r[k_oc] && sel_r[k_oc]) begin
                    oc_nxt[k_oc] = oc3d_r[k_oc];
                end
            end
        end
    end

    // Pin 3 doubles as the accumulator input
    wire apin = pin_s_r[`ACC_PIN];
    wire apin_p = pin_p_r[`ACC_PIN];
    wire a_rise = apin & ~apin_p;
    wire a_fall = ~apin & apin_p;
    wire a_evt = aedg ? a_rise : a_fall;
    // In gated mode the active level is low when the edge bit is set, so its end is a rise
    wire a_gate = aedg ? ~apin : apin;
    wire a_inc = amod ? (div64 && a_gate) : a_evt;
    wire ain_set = a_evt;
    wire aov_set = a_inc && (acc_r == `CNT_MAX);

    wire acc_touch = done && (i_paddr == `A_ACC) && ffc;
    wire cnt_touch = done && (i_paddr == `A_CNT) && ffc;
    wire flg_wr = wr && (i_paddr == `A_FLAGS);
    wire tof_clr = (flg_wr && i_pwdata[`FLG_TOF]) || cnt_touch;
    wire ain_clr = (flg_wr && i_pwdata[`FLG_AIN]) || acc_touch;
    wire aov_clr = (flg_wr && i_pwdata[`FLG_AOV]) || acc_touch;

    // Each source requests service only while its enable is set
    wire [3:0] irq_ch = chf_r & chie_r;
    wire irq_tof = tof_r & ctrl_r[`CTRL_TOI];
    wire irq_ain = ain_r & ctrl_r[`CTRL_AINI];
    wire irq_aov = aov_r & ctrl_r[`CTRL_AOVI];

    reg [3:0] chf_clr;
    reg [31:0] rdata;
    reg hit;
    always @* begin
        chf_clr = flg_wr ? i_pwdata[3:0] : 4'h0;
        // Fast clear follows how software naturally services each kind of channel
        for (k_clr = 0; k_clr < NCH; k_clr = k_clr + 1) begin
            if (ffc && i_paddr == ch_addr(k_clr[1:0])) begin
                if ((sel_r[k_clr] && wr) || (!sel_r[k_clr] && rd)) begin
                    chf_clr[k_clr] = 1'b1;
                end
            end
        end
        // Unmapped words read zero and raise the error response
        hit = 1'b1;
        rdata = 32'h0000_0000;
        case (i_paddr)
            `A_CTRL: rdata[`CTRL_W-1:0] = ctrl_r;
            `A_CHCFG: rdata[7:0] = {chie_r, sel_r};
            `A_EDGE: rdata[7:0] = edge_r;
            `A_OUTCTL: rdata[7:0] = outctl_r;
            `A_FORCE: rdata = 32'h0000_0000;
            `A_OC3: rdata[11:0] = {oc3d_r, 4'h0, oc3m_r};
            `A_CNT: rdata[15:0] = cnt_r;
            `A_FLAGS: rdata[6:0] = {aov_r, ain_r, tof_r, chf_r};
            `A_PORT: rdata[3:0] = (dir_r & port_r) | (~dir_r & pin_s_r);
            `A_DIR: rdata[3:0] = dir_r;
            `A_ACC: rdata[15:0] = acc_r;
            `A_CH0: rdata[15:0] = ch_r[0];
            `A_CH1: rdata[15:0] = ch_r[1];
            `A_CH2: rdata[15:0] = ch_r[2];
            `A_CH3: rdata[15:0] = ch_r[3];
            default: hit = 1'b0;
        endcase
    end

    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h0000_0000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            pin_m_r <= 4'h0;
            pin_s_r <= 4'h0;
            pin_p_r <= 4'h0;
        end else if (i_clk_en) begin
            o_pready <= acc_first;
            o_pslverr <= acc_first && !hit;
            o_prdata <= (acc_first && !i_pwrite) ? rdata : 32'h0000_0000;
            // Two stages settle the asynchronous pins; the third only keeps edge history
            pin_m_r <= i_pin;
            pin_s_r <= pin_m_r;
            pin_p_r <= pin_s_r;
        end
    end

    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            ctrl_r <= {`CTRL_W{1'b0}};
            sel_r <= 4'h0;
            chie_r <= 4'h0;
            edge_r <= 8'h00;
            outctl_r <= 8'h00;
            oc3m_r <= 4'h0;
            oc3d_r <= 4'h0;
            port_r <= 4'h0;
            dir_r <= 4'h0;
        end else if (i_clk_en && wr) begin
            case (i_paddr)
                `A_CTRL: begin
                    ctrl_r <= i_pwdata[`CTRL_W-1:0];
                end
                `A_CHCFG: begin
                    sel_r <= i_pwdata[3:0];
                    chie_r <= i_pwdata[7:4];
                end
                `A_EDGE: begin
                    edge_r <= i_pwdata[7:0];
                end
                `A_OUTCTL: begin
                    outctl_r <= i_pwdata[7:0];
                end
                `A_OC3: begin
                    oc3m_r <= i_pwdata[3:0];
                    oc3d_r <= i_pwdata[`OC3_DATA_HI:`OC3_DATA_LO];
                end
                `A_PORT: begin
                    port_r <= i_pwdata[3:0];
                end
                `A_DIR: begin
                    dir_r <= i_pwdata[3:0];
                end
                default: ;
            endcase
        end
    end

    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            cnt_r <= `CNT_ZERO;
            presc_r <= 7'h00;
            pr_act_r <= 3'b000;
            tof_r <= 1'b0;
            oc_r <= 4'h0;
        end else if (i_clk_en) begin
            // Held at zero while disabled so every enable starts from a clean phase
            presc_r <= presc_nxt;
            if (tick) begin
                cnt_r <= cnt_nxt;
                if (cnt_reset || cnt_wrap) begin
                    pr_act_r <= pr_sel;
                end
            end else if (!en) begin
                // Nothing is counting, so a new divisor can apply at once
                pr_act_r <= pr_sel;
            end
            if (tof_set) begin
                tof_r <= 1'b1;
            end else if (tof_clr) begin
                tof_r <= 1'b0;
            end
            oc_r <= oc_nxt;
        end
    end

    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            chf_r <= 4'h0;
            ch_r[0] <= 16'h0000;
            ch_r[1] <= 16'h0000;
            ch_r[2] <= 16'h0000;
            ch_r[3] <= 16'h0000;
        end else if (i_clk_en) begin
            for (k_ch = 0; k_ch < NCH; k_ch = k_ch + 1) begin
                // A capture outranks a software write landing in the same cycle
                if (cap_hit[k_ch]) begin
                    ch_r[k_ch] <= cnt_r;
                end else if (wr && sel_r[k_ch] && i_paddr == ch_addr(k_ch[1:0])) begin
                    ch_r[k_ch] <= i_pwdata[15:0];
                end
                if (cap_hit[k_ch] || cmp_hit[k_ch]) begin
                    chf_r[k_ch] <= 1'b1;
                end else if (chf_clr[k_ch]) begin
                    chf_r[k_ch] <= 1'b0;
                end
            end
        end
    end

    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            acc_r <= 16'h0000;
            ain_r <= 1'b0;
            aov_r <= 1'b0;
        end else if (i_clk_en) begin
            // A load in the cycle of a counted edge is lost; counting wins
            if (a_inc) begin
                acc_r <= acc_nxt;
            end else if (wr && i_paddr == `A_ACC) begin
                acc_r <= i_pwdata[15:0];
            end
            if (ain_set) begin
                ain_r <= 1'b1;
            end else if (ain_clr) begin
                ain_r <= 1'b0;
            end
            if (aov_set) begin
                aov_r <= 1'b1;
            end else if (aov_clr) begin
                aov_r <= 1'b0;
            end
        end
    end

    reg [3:0] pin_nxt;
    reg [3:0] oe_nxt;
    integer k_pin;

    // Compare logic overrides direction without touching it; otherwise the latch and
    // the direction bit drive the pin as plain I/O
    always @* begin
        pin_nxt = port_r;
        oe_nxt = dir_r;
        for (k_pin = 0; k_pin < NCH; k_pin = k_pin + 1) begin
            if (en && pin_own[k_pin]) begin
                pin_nxt[k_pin] = oc_nxt[k_pin];
                oe_nxt[k_pin] = 1'b1;
            end
        end
    end

    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_pin <= 4'h0;
            o_pin_oe <= 4'h0;
            o_irq <= 1'b0;
        end else if (i_clk_en) begin
            o_pin <= pin_nxt;
            o_pin_oe <= oe_nxt;
            o_irq <= (|irq_ch) | irq_tof | irq_ain | irq_aov;
        end
    end

endmodule // capture_compare_pulse_accumulator

// >>> ccpa_regs.vh
`ifndef CCPA_REGS_VH
`define CCPA_REGS_VH
`define A_CTRL 12'h000
`define A_CHCFG 12'h004
`define A_EDGE 12'h008
`define A_OUTCTL 12'h00C
`define A_FORCE 12'h010
`define A_OC3 12'h014
`define A_CNT 12'h018
`define A_FLAGS 12'h01C
`define A_PORT 12'h020
`define A_DIR 12'h024
`define A_ACC 12'h028
`define A_CH0 12'h030
`define A_CH1 12'h034
`define A_CH2 12'h038
`define A_CH3 12'h03C
`define CTRL_EN 0
`define CTRL_FFC 1
`define CTRL_COUNTER_RESET_ON_CH3 2
`define CTRL_PR_LO 3
`define CTRL_PR_HI 5
`define CTRL_TOI 6
`define CTRL_AMOD 7
`define CTRL_AEDG 8
`define CTRL_AOVI 9
`define CTRL_AINI 10
`define CTRL_W 11
`define FLG_TOF 4
`define FLG_AIN 5
`define FLG_AOV 6
`define OC3_DATA_LO 8
`define OC3_DATA_HI 11
`define CNT_MAX 16'hFFFF
`define CNT_ZERO 16'h0000
`define DIV64_PHASE 6'h3F
`define ACC_PIN 3
`endif

// >>> ccpa_properties.sv
`timescale 1ns/1ps
`include "ccpa_regs.vh"
module ccpa_properties (
    input wire i_sys_clk,
    input wire i_rst_n,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [31:0] o_prdata,
    input wire o_pready,
    input wire o_pslverr,
    input wire [3:0] o_pin,
    input wire [3:0] o_pin_oe
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // Shadows follow the commit edge only, so the registered pins can lag them by design
    logic en_q;
    logic [3:0] dir_q;
    logic [3:0] lat_q;
    wire done = i_psel && i_penable && o_pready;
    wire bad = (i_paddr == 12'h02C) || (i_paddr > 12'h03C);
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            en_q <= 1'b0;
            dir_q <= 4'h0;
            lat_q <= 4'h0;
        end else if (done && i_pwrite) begin
            if (i_paddr == `A_CTRL) en_q <= i_pwdata[`CTRL_EN];
            if (i_paddr == `A_DIR) dir_q <= i_pwdata[3:0];
            if (i_paddr == `A_PORT) lat_q <= i_pwdata[3:0];
        end
    end
    ready_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("ready held longer than one cycle");
    ready_wait_a: assert property ($rose(i_penable) && i_psel |=> o_pready)
        else $error("no ready one cycle into access phase");
    ready_cause_a: assert property (o_pready |-> $past(i_psel && i_penable) && i_penable)
        else $error("ready without access phase");
    err_unmapped_a: assert property (done && bad |-> o_pslverr)
        else $error("unmapped access not refused");
    err_mapped_a: assert property (o_pready && !bad |-> !o_pslverr)
        else $error("mapped access refused");
    idle_data_a: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside transfer");
    force_read_a: assert property (done && !i_pwrite && i_paddr == `A_FORCE |-> o_prdata == 32'h0)
        else $error("force register read not zero");
    upper_zero_a: assert property (done |-> o_prdata[31:16] == 16'h0)
        else $error("upper read bits not zero");
    plain_io_a: assert property (!en_q && !$past(en_q, 2) && $stable(dir_q) && $stable(lat_q)
        |-> o_pin_oe == dir_q && (o_pin & dir_q) == (lat_q & dir_q))
        else $error("disabled timer pins not plain io");
endmodule // ccpa_properties
bind capture_compare_pulse_accumulator ccpa_properties u_ccpa_properties (.*);

// >>> pin_partner.sv
`timescale 1ns/1ps
module pin_partner (
    input wire i_sys_clk,
    input wire [3:0] i_drive,
    input wire [3:0] i_drive_oe,
    output wire [3:0] o_level
);
    logic [3:0] ext = 4'h0;
    assign o_level = (i_drive & i_drive_oe) | (ext & ~i_drive_oe);
    task set(input logic [3:0] v);
        @(posedge i_sys_clk);
        ext <= v;
    endtask
    // Each level is held five clocks, above the two-clock minimum width
    task pulse(input int n);
        repeat (2) begin
            @(posedge i_sys_clk);
            ext[n] <= ~ext[n];
            repeat (4) @(posedge i_sys_clk);
        end
    endtask
endmodule // pin_partner

// >>> tb_top.sv
`timescale 1ns/1ps
`include "ccpa_regs.vh"
module tb_top;
    typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
    logic i_sys_clk, i_rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic [3:0] lvl, pin_o, pin_oe;
    int n_tests = 0;
    int n_mismatch = 0;
    row_t rows [19] = '{'{`A_CTRL, 32'h7FE, 32'h7FE, 1'b0}, '{`A_CTRL, 32'h0, 32'h0, 1'b0},
        '{`A_EDGE, 32'hAA, 32'hAA, 1'b0}, '{`A_EDGE, 32'h0, 32'h0, 1'b0},
        '{`A_OUTCTL, 32'h55, 32'h55, 1'b0}, '{`A_OUTCTL, 32'h0, 32'h0, 1'b0},
        '{`A_OC3, 32'hFFFF, 32'hF0F, 1'b0}, '{`A_OC3, 32'h0, 32'h0, 1'b0},
        '{`A_CNT, 32'h1234, 32'h0, 1'b0}, '{`A_CHCFG, 32'hFF, 32'hFF, 1'b0},
        '{`A_CH1, 32'h1234, 32'h1234, 1'b0}, '{`A_CHCFG, 32'h0, 32'h0, 1'b0},
        '{`A_CH2, 32'h55, 32'h0, 1'b0}, '{`A_FORCE, 32'hF, 32'h0, 1'b0},
        '{`A_ACC, 32'hBEEF, 32'hBEEF, 1'b0}, '{`A_DIR, 32'hF, 32'hF, 1'b0},
        '{`A_PORT, 32'h5, 32'h5, 1'b0}, '{`A_DIR, 32'h0, 32'h0, 1'b0},
        '{12'h02C, 32'h1, 32'h0, 1'b1}};
    capture_compare_pulse_accumulator u_capture_compare_pulse_accumulator (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(1'b1), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_pin(lvl),
        .o_pin(pin_o), .o_pin_oe(pin_oe), .o_irq(irq));
    pin_partner u_pin_partner (.i_sys_clk(i_sys_clk), .i_drive(pin_o), .i_drive_oe(pin_oe),
        .o_level(lvl));
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_sys_clk);
        penable <= 1'b1;
        do @(posedge i_sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        cmp(rd, x);
    endtask
    task results;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        n_mismatch++;
        results();
    end
    initial begin
        {i_rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (10) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].x);
            cmp({31'h0, err}, {31'h0, rows[i].e});
        end
        $display("register table done");
        u_pin_partner.set(4'hA);
        repeat (6) @(posedge i_sys_clk);
        rdc(`A_PORT, 32'hA);
        $display("port input read done");
        apb(1'b1, `A_CHCFG, 32'h11);
        apb(1'b1, `A_CH0, 32'h40);
        apb(1'b1, `A_OUTCTL, 32'h1);
        apb(1'b1, `A_CTRL, 32'h1);
        repeat (100) @(posedge i_sys_clk);
        rdc(`A_FLAGS, 32'h1);
        cmp({26'h0, irq, pin_oe[0], pin_o[0], 3'h0}, 32'h38);
        rdc(`A_DIR, 32'h0);
        apb(1'b1, `A_FLAGS, 32'h0);
        rdc(`A_FLAGS, 32'h1);
        apb(1'b1, `A_FLAGS, 32'h1);
        apb(1'b1, `A_FORCE, 32'h1);
        repeat (3) @(posedge i_sys_clk);
        rdc(`A_FLAGS, 32'h0);
        cmp({30'h0, irq, pin_o[0]}, 32'h0);
        $display("output compare done");
        apb(1'b1, `A_CTRL, 32'h500);
        apb(1'b1, `A_OUTCTL, 32'h0);
        apb(1'b1, `A_ACC, 32'hFFFE);
        repeat (2) u_pin_partner.pulse(3);
        repeat (4) @(posedge i_sys_clk);
        rdc(`A_ACC, 32'h0);
        rdc(`A_FLAGS, 32'h60);
        cmp({31'h0, irq}, 32'h1);
        $display("event counter done");
        apb(1'b1, `A_CHCFG, 32'h0);
        apb(1'b1, `A_EDGE, 32'h10);
        apb(1'b1, `A_FLAGS, 32'h7F);
        apb(1'b1, `A_CTRL, 32'h1);
        u_pin_partner.pulse(2);
        repeat (4) @(posedge i_sys_clk);
        rdc(`A_FLAGS, 32'h4);
        apb(1'b0, `A_CH2, 32'h0);
        v = rd;
        apb(1'b0, `A_CNT, 32'h0);
        cmp({31'h0, v != 32'h0 && v < rd}, 32'h1);
        apb(1'b1, `A_CTRL, 32'h3);
        rdc(`A_CH2, v);
        rdc(`A_FLAGS, 32'h0);
        $display("input capture done");
        results();
    end
endmodule // tb_top
